//--- dtc_pkg.sv
// How it works
// - stop bit halts after current atomic transfer
// - completed stop zeroes current count and addresses
// - enable bit gates all request handling
// - no auto reload: enable clears at zero
// - stop set: enable clears after atomic transfer
// - software trigger requests; clears itself on start
// - initial values apply only at count zero
// - other control writes act at once
// - mode bit picks software or hardware trigger
// - source field used only in hardware mode
// - source codes: serial, two spi, two i2c, adc
// - count loads from initial, decrements per transfer
package dtc_pkg;
  localparam logic [7:0] OFS_INIT_SRC = 8'h00;
  localparam logic [7:0] OFS_INIT_DST = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CUR_SRC = 8'h18;
  localparam logic [7:0] OFS_CUR_DST = 8'h1C;
  localparam logic [7:0] OFS_TRIG_CTL = 8'h20;
  localparam logic [7:0] OFS_REQ_SEL = 8'h24;
  localparam int BIT_TRIG = 0;
  localparam int BIT_ON = 1;
  localparam int BIT_STOP = 2;
  localparam int BIT_MODE = 0;
  localparam int BIT_RELOAD = 22;
  localparam int BIT_BUSY = 20;
  localparam int CNT_W = 20;
  localparam int ADR_W = 31;
  localparam logic [4:0] SRC_RESET = 5'h00;
  localparam logic [19:0] CNT_RESET = 20'h00000;
  localparam logic [30:0] ADR_RESET = 31'h00000000;
  localparam logic [30:0] ADR_STEP = 31'h00000004;
  typedef enum logic [0:0] {
    DTC_IDLE = 1'h0,
    DTC_BUSY = 1'h1
  } dtc_state_t;
  // defined peripheral request codes; all others are reserved
  function automatic logic srcValid(input logic [4:0] code);
    srcValid = (code <= 5'h01) || (code >= 5'h0A && code <= 5'h0D) ||
               (code >= 5'h12 && code <= 5'h16);
  endfunction : srcValid
endpackage : dtc_pkg

//--- dtc_req_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dtc_req_if #(parameter int NREQ = 32);
  logic [NREQ-1:0] hwReq;
  logic [4:0] srcSel;
  logic modeHw;
  logic armed;
  logic selReq;
  modport mux (input hwReq, input srcSel, input modeHw, input armed, output selReq);
  modport ctl (output hwReq, output srcSel, output modeHw, output armed, input selReq);
endinterface : dtc_req_if
`default_nettype wire

//--- dtc_req_mux.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_req_mux (
  dtc_req_if.mux rq
);
  // a line is only seen while the channel can take it, nothing is latched
  always_comb begin
    rq.selReq = rq.armed && rq.modeHw && dtc_pkg::srcValid(rq.srcSel) &&
                rq.hwReq[rq.srcSel];
  end
endmodule : dtc_req_mux
`default_nettype wire

//--- dtc_channel.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dtc_channel #(
  parameter int NREQ = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic [NREQ-1:0] hwReq,
  input wire logic xferDone,
  output logic xferReq,
  output logic chanOn,
  output logic autoReload,
  output logic [19:0] curCount,
  output logic [30:0] curSrcAddr,
  output logic [30:0] curDstAddr
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [30:0] initSrc;
    logic [30:0] initDst;
    logic [19:0] cfgCount;
    logic reload;
    logic on;
    logic stop;
    logic trig;
    logic modeHw;
    logic [4:0] srcSel;
    logic [19:0] cnt;
    logic [30:0] curSrc;
    logic [30:0] curDst;
    logic xfer;
    dtc_pkg::dtc_state_t state;
  } dtc_regs_t;

  dtc_regs_t s_ff;
  dtc_regs_t nxt_s;
  logic access;
  logic wrTrig;
  logic start;
  logic [19:0] effCount;
  dtc_req_if #(.NREQ(NREQ)) rq ();

  assign rq.hwReq = hwReq;
  assign rq.srcSel = s_ff.srcSel;
  assign rq.modeHw = s_ff.modeHw;
  assign rq.armed = s_ff.on && !s_ff.stop && (s_ff.state == dtc_pkg::DTC_IDLE);

  dtc_req_mux u_mux (
    .rq(rq)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  assign access = wbCyc && wbStb && !s_ff.ack;
  assign wrTrig = access && wbWe && (wbAdr == dtc_pkg::OFS_TRIG_CTL);
  // a fresh run takes the initial values only once the current count is spent
  assign effCount = (s_ff.cnt == dtc_pkg::CNT_RESET) ? s_ff.cfgCount : s_ff.cnt;
  assign start = (s_ff.state == dtc_pkg::DTC_IDLE) && s_ff.on && !s_ff.stop &&
                 (effCount != dtc_pkg::CNT_RESET) &&
                 (s_ff.modeHw ? rq.selReq : s_ff.trig);

  always_comb begin
    logic [31:0] cur;
    logic [31:0] w;
    cur = 32'h00000000;
    w = 32'h00000000;
    nxt_s = s_ff;
    nxt_s.ack = access;
    unique case (s_ff.state)
      dtc_pkg::DTC_IDLE: begin
        if (s_ff.stop) begin
          // nothing in flight, so the stop is immediate
          nxt_s.on = 1'b0;
          nxt_s.stop = 1'b0;
          nxt_s.cnt = dtc_pkg::CNT_RESET;
          nxt_s.curSrc = dtc_pkg::ADR_RESET;
          nxt_s.curDst = dtc_pkg::ADR_RESET;
        end else if (start) begin
          nxt_s.trig = 1'b0;
          if (s_ff.cnt == dtc_pkg::CNT_RESET) begin
            nxt_s.cnt = s_ff.cfgCount;
            nxt_s.curSrc = s_ff.initSrc;
            nxt_s.curDst = s_ff.initDst;
          end
          nxt_s.xfer = 1'b1;
          nxt_s.state = dtc_pkg::DTC_BUSY;
        end
      end
      dtc_pkg::DTC_BUSY: begin
        if (xferDone) begin
          nxt_s.xfer = 1'b0;
          nxt_s.state = dtc_pkg::DTC_IDLE;
          if (s_ff.stop) begin
            nxt_s.on = 1'b0;
            nxt_s.stop = 1'b0;
            nxt_s.cnt = dtc_pkg::CNT_RESET;
            nxt_s.curSrc = dtc_pkg::ADR_RESET;
            nxt_s.curDst = dtc_pkg::ADR_RESET;
          end else begin
            nxt_s.cnt = s_ff.cnt - 20'h00001;
            nxt_s.curSrc = s_ff.curSrc + dtc_pkg::ADR_STEP;
            nxt_s.curDst = s_ff.curDst + dtc_pkg::ADR_STEP;
            if (s_ff.cnt == 20'h00001 && !s_ff.reload) begin
              nxt_s.on = 1'b0;
            end
          end
        end
      end
    endcase
    if (access) begin
      unique case (wbAdr)
        dtc_pkg::OFS_INIT_SRC: cur = {1'b0, s_ff.initSrc};
        dtc_pkg::OFS_INIT_DST: cur = {1'b0, s_ff.initDst};
        dtc_pkg::OFS_CONFIG: cur = {9'h000, s_ff.reload, 2'h0, s_ff.cfgCount};
        dtc_pkg::OFS_STATUS: cur = {11'h000, s_ff.state == dtc_pkg::DTC_BUSY, s_ff.cnt};
        dtc_pkg::OFS_CUR_SRC: cur = {1'b0, s_ff.curSrc};
        dtc_pkg::OFS_CUR_DST: cur = {1'b0, s_ff.curDst};
        dtc_pkg::OFS_TRIG_CTL: cur = {29'h00000000, s_ff.stop, s_ff.on, s_ff.trig};
        dtc_pkg::OFS_REQ_SEL: cur = {26'h0000000, s_ff.srcSel, s_ff.modeHw};
        default: cur = 32'h00000000;
      endcase
      nxt_s.rdat = wbWe ? 32'h00000000 : cur;
      w = merge(cur, wbDatI, wbSel);
      // software writes land after the hardware update, so a written 1 wins
      if (wbWe) begin
        unique case (wbAdr)
          dtc_pkg::OFS_INIT_SRC: nxt_s.initSrc = w[30:0];
          dtc_pkg::OFS_INIT_DST: nxt_s.initDst = w[30:0];
          dtc_pkg::OFS_CONFIG: begin
            nxt_s.cfgCount = w[19:0];
            nxt_s.reload = w[dtc_pkg::BIT_RELOAD];
          end
          dtc_pkg::OFS_TRIG_CTL: begin
            nxt_s.trig = w[dtc_pkg::BIT_TRIG] || nxt_s.trig;
            nxt_s.on = w[dtc_pkg::BIT_ON];
            nxt_s.stop = w[dtc_pkg::BIT_STOP] || nxt_s.stop;
          end
          dtc_pkg::OFS_REQ_SEL: begin
            nxt_s.modeHw = w[dtc_pkg::BIT_MODE];
            nxt_s.srcSel = w[5:1];
          end
          default: begin
          end
        endcase
      end
    end else begin
      nxt_s.rdat = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '{ack: 1'b0, rdat: 32'h00000000, initSrc: dtc_pkg::ADR_RESET,
                initDst: dtc_pkg::ADR_RESET, cfgCount: dtc_pkg::CNT_RESET, reload: 1'b0,
                on: 1'b0, stop: 1'b0, trig: 1'b0, modeHw: 1'b0,
                srcSel: dtc_pkg::SRC_RESET, cnt: dtc_pkg::CNT_RESET,
                curSrc: dtc_pkg::ADR_RESET, curDst: dtc_pkg::ADR_RESET, xfer: 1'b0,
                state: dtc_pkg::DTC_IDLE};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wbAck = s_ff.ack;
  assign wbDatO = s_ff.rdat;
  assign xferReq = s_ff.xfer;
  assign chanOn = s_ff.on;
  assign autoReload = s_ff.reload;
  assign curCount = s_ff.cnt;
  assign curSrcAddr = s_ff.curSrc;
  assign curDstAddr = s_ff.curDst;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_stop_idle: assert property (
    s_ff.stop && s_ff.on && s_ff.state == dtc_pkg::DTC_IDLE && !wrTrig
    |=> !s_ff.on && s_ff.cnt == dtc_pkg::CNT_RESET)
    else $error("idle stop did not halt at once");
  a_stop_zeroes: assert property (
    $fell(s_ff.on) && $past(s_ff.stop)
    |-> s_ff.cnt == dtc_pkg::CNT_RESET && s_ff.curSrc == dtc_pkg::ADR_RESET &&
        s_ff.curDst == dtc_pkg::ADR_RESET)
    else $error("current values not zero after stop");
  a_stop_busy: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && s_ff.stop && !xferDone && !wrTrig
    |=> s_ff.on == $past(s_ff.on) && s_ff.state == dtc_pkg::DTC_BUSY)
    else $error("stop cut an atomic transfer short");
  a_off_no_start: assert property (
    !s_ff.on |-> !start ##1 !$rose(s_ff.xfer))
    else $error("disabled channel started a transfer");
  a_noreload_off: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && xferDone && s_ff.cnt == 20'h00001 &&
    !s_ff.reload && !s_ff.stop && !wrTrig
    |=> !s_ff.on && s_ff.cnt == dtc_pkg::CNT_RESET)
    else $error("enable kept at count zero without reload");
  a_trig_clear: assert property (
    start && !s_ff.modeHw && !wrTrig |=> !s_ff.trig && s_ff.xfer)
    else $error("trigger not cleared on start");
  a_init_held: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && !xferDone |=> $stable(s_ff.cnt) && $stable(s_ff.curSrc))
    else $error("current values changed mid transfer");
  a_mode_write: assert property (
    access && wbWe && wbAdr == dtc_pkg::OFS_REQ_SEL && wbSel[0]
    |=> s_ff.modeHw == $past(wbDatI[0]) && s_ff.srcSel == $past(wbDatI[5:1]))
    else $error("mode write not immediate");
  a_sw_only: assert property (
    !s_ff.modeHw && !s_ff.trig |-> !start)
    else $error("software mode started without trigger");
  a_hw_start: assert property (
    s_ff.modeHw && rq.armed && rq.selReq && effCount != dtc_pkg::CNT_RESET
    |-> start ##1 s_ff.state == dtc_pkg::DTC_BUSY)
    else $error("selected hardware request not served");
  a_count_dec: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && xferDone && !s_ff.stop
    |=> s_ff.cnt == $past(s_ff.cnt) - 20'h00001)
    else $error("count did not step down");
  a_bus_ack: assert property (
    access |=> wbAck ##1 !wbAck)
    else $error("bus answer not one cycle");

  a_ack_rdat_zero: assert property (
    !wbAck |-> wbDatO == 32'h00000000)
    else $error("read data shown without ack");

  a_read_trig: assert property (
    access && !wbWe && wbAdr == dtc_pkg::OFS_TRIG_CTL
    |=> wbAck && wbDatO == {29'h00000000, $past(s_ff.stop), $past(s_ff.on),
                            $past(s_ff.trig)})
    else $error("trigger control read back wrong");

  a_read_sel: assert property (
    access && !wbWe && wbAdr == dtc_pkg::OFS_REQ_SEL
    |=> wbDatO == {26'h0000000, $past(s_ff.srcSel), $past(s_ff.modeHw)})
    else $error("source select read back wrong");

  a_read_count: assert property (
    access && !wbWe && wbAdr == dtc_pkg::OFS_STATUS
    |=> wbDatO[19:0] == $past(s_ff.cnt) && wbDatO[31:21] == 11'h000)
    else $error("current count read back wrong");

  a_read_cur: assert property (
    access && !wbWe && wbAdr == dtc_pkg::OFS_CUR_DST
    |=> wbDatO == {1'b0, $past(s_ff.curDst)})
    else $error("current destination read back wrong");

  a_stop_clears: assert property (
    s_ff.stop && s_ff.state == dtc_pkg::DTC_IDLE && !wrTrig |=> !s_ff.stop)
    else $error("stop bit left set after idle stop");

  a_stop_finish: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && s_ff.stop && xferDone && !wrTrig
    |=> !s_ff.on && !s_ff.stop && s_ff.state == dtc_pkg::DTC_IDLE)
    else $error("stop not done after atomic transfer");

  a_stop_zero_cur: assert property (
    s_ff.stop && (s_ff.state == dtc_pkg::DTC_IDLE || xferDone)
    |=> s_ff.cnt == dtc_pkg::CNT_RESET && s_ff.curSrc == dtc_pkg::ADR_RESET &&
        s_ff.curDst == dtc_pkg::ADR_RESET)
    else $error("stop left current values set");

  a_xfer_holds: assert property (
    s_ff.xfer && !xferDone |=> s_ff.xfer)
    else $error("atomic transfer request dropped early");

  a_xfer_ends: assert property (
    s_ff.xfer && xferDone |=> !s_ff.xfer && s_ff.state == dtc_pkg::DTC_IDLE)
    else $error("transfer request held after done");

  a_sw_no_select: assert property (
    !s_ff.modeHw |-> !rq.selReq)
    else $error("hardware line selected in software mode");

  a_reserved_code: assert property (
    rq.srcSel inside {[5'h02:5'h09], [5'h0E:5'h11], [5'h17:5'h1F]} |-> !rq.selReq)
    else $error("reserved source code selected a line");

  a_defined_code: assert property (
    rq.armed && rq.modeHw && rq.hwReq[rq.srcSel] &&
    rq.srcSel inside {[5'h00:5'h01], [5'h0A:5'h0D], [5'h12:5'h16]} |-> rq.selReq)
    else $error("defined source code not selected");

  a_hw_dropped: assert property (
    !rq.armed |-> !rq.selReq)
    else $error("hardware request seen while not armed");

  a_busy_no_start: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY |-> !start)
    else $error("start while a transfer runs");

  a_load_init: assert property (
    start && s_ff.cnt == dtc_pkg::CNT_RESET
    |=> s_ff.cnt == $past(s_ff.cfgCount) && s_ff.curSrc == $past(s_ff.initSrc) &&
        s_ff.curDst == $past(s_ff.initDst))
    else $error("initial values not loaded at start");

  a_keep_cur: assert property (
    start && s_ff.cnt != dtc_pkg::CNT_RESET
    |=> $stable(s_ff.cnt) && $stable(s_ff.curSrc) && $stable(s_ff.curDst))
    else $error("initial values applied before count spent");

  a_no_empty_run: assert property (
    s_ff.cnt == dtc_pkg::CNT_RESET && s_ff.cfgCount == dtc_pkg::CNT_RESET |-> !start)
    else $error("start with nothing to transfer");

  a_addr_step: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && xferDone && !s_ff.stop
    |=> s_ff.curSrc == $past(s_ff.curSrc) + dtc_pkg::ADR_STEP &&
        s_ff.curDst == $past(s_ff.curDst) + dtc_pkg::ADR_STEP)
    else $error("current addresses did not step");

  a_reload_on: assert property (
    s_ff.state == dtc_pkg::DTC_BUSY && xferDone && s_ff.cnt == 20'h00001 &&
    s_ff.reload && !s_ff.stop && !wrTrig |=> s_ff.on)
    else $error("channel turned off with reload set");

  a_on_write: assert property (
    wrTrig && wbSel[0] |=> s_ff.on == $past(wbDatI[dtc_pkg::BIT_ON]))
    else $error("enable write not immediate");

  a_trig_write: assert property (
    wrTrig && wbSel[0] && wbDatI[dtc_pkg::BIT_TRIG] |=> s_ff.trig)
    else $error("written trigger lost");

  a_reload_write: assert property (
    access && wbWe && wbAdr == dtc_pkg::OFS_CONFIG && wbSel[2]
    |=> s_ff.reload == $past(wbDatI[dtc_pkg::BIT_RELOAD]))
    else $error("reload write not immediate");

  a_hw_ignores_trig: assert property (
    s_ff.modeHw && !rq.selReq |-> !start)
    else $error("hardware mode started without its line");

  c_hw_run: cover property (s_ff.modeHw && start);
  c_stop_busy: cover property (s_ff.stop && s_ff.state == dtc_pkg::DTC_BUSY ##[1:20] !s_ff.on);
  c_run_out: cover property (s_ff.on && !s_ff.reload ##[1:50] $fell(s_ff.on) && !$past(s_ff.stop));
  c_sw_run: cover property (!s_ff.modeHw && start);
  c_reload_run: cover property (s_ff.reload && xferDone && s_ff.cnt == 20'h00001);
endmodule : dtc_channel
`default_nettype wire

//--- dtc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_periph_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqOn,
  input wire logic [4:0] reqCode,
  input wire logic [3:0] doneDelay,
  input wire logic xferReq,
  output logic [31:0] hwReq,
  output logic xferDone
);
  logic [3:0] waitCnt;
  // one peripheral line, held as a level while the bench asks for it
  always_comb hwReq = reqOn ? (32'h00000001 << reqCode) : 32'h00000000;
  // datapath side: one done pulse after doneDelay+1 cycles of request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt <= 4'h0;
      xferDone <= 1'b0;
    end else if (xferReq && !xferDone) begin
      waitCnt <= waitCnt + 4'h1;
      xferDone <= (waitCnt == doneDelay);
    end else begin
      waitCnt <= 4'h0;
      xferDone <= 1'b0;
    end
  end
endmodule : dtc_periph_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h00000000;
  logic reqOn = 1'b0;
  logic [4:0] reqCode = 5'h00;
  logic [3:0] doneDelay = 4'h4;
  logic [31:0] wbDatO, hwReq, rd;
  logic wbAck, xferDone, xferReq, chanOn, autoReload, hit, valid;
  logic [19:0] curCount;
  logic [30:0] curSrcAddr, curDstAddr;
  int badCount = 0;
  int testsRun = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  dtc_channel dtc_channel_inst (.clk(clk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .hwReq(hwReq), .xferDone(xferDone), .xferReq(xferReq), .chanOn(chanOn),
    .autoReload(autoReload), .curCount(curCount), .curSrcAddr(curSrcAddr),
    .curDstAddr(curDstAddr));
  dtc_periph_model dtc_periph_model_inst (.clk(clk), .nrst(nrst), .reqOn(reqOn),
    .reqCode(reqCode), .doneDelay(doneDelay), .xferReq(xferReq), .hwReq(hwReq),
    .xferDone(xferDone));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tallyAndFinish
  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic wbAccess(input logic we, input logic [7:0] adr, input logic [31:0] din);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= din;
    wbSel <= 4'hF;
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wbAccess
  task automatic wr(input logic [7:0] adr, input logic [31:0] din);
    wbAccess(1'b1, adr, din);
  endtask : wr
  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    wbAccess(1'b0, adr, 32'h00000000);
    check(rd, exp);
  endtask : rdChk
  task automatic waitReq(input logic lvl, input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(negedge clk);
      hit = (xferReq === lvl);
    end
  endtask : waitReq
  task automatic setReq(input logic on);
    @(posedge clk);
    reqOn <= on;
  endtask : setReq
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      tallyAndFinish();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rdChk(dtc_pkg::OFS_TRIG_CTL, 32'h00000000);
    rdChk(dtc_pkg::OFS_REQ_SEL, 32'h00000000);
    rdChk(8'h30, 32'h00000000);
    wr(dtc_pkg::OFS_INIT_SRC, 32'h00000100);
    wr(dtc_pkg::OFS_INIT_DST, 32'h00000200);
    wr(dtc_pkg::OFS_CONFIG, 32'h00000002);
    wr(dtc_pkg::OFS_REQ_SEL, 32'h00000015);
    reqCode <= 5'h0A;
    setReq(1'b1);
    waitReq(1'b1, 8);
    check({31'h0, hit}, 32'h00000000);
    setReq(1'b0);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000002);
    waitReq(1'b1, 8);
    check({31'h0, hit}, 32'h00000000);
    wr(dtc_pkg::OFS_REQ_SEL, 32'h00000000);
    reqCode <= 5'h00;
    setReq(1'b1);
    waitReq(1'b1, 8);
    check({31'h0, hit}, 32'h00000000);
    setReq(1'b0);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000003);
    waitReq(1'b1, 8);
    check({31'h0, hit}, 32'h00000001);
    rdChk(dtc_pkg::OFS_TRIG_CTL, 32'h00000002);
    wr(dtc_pkg::OFS_CONFIG, 32'h00000005);
    waitReq(1'b0, 20);
    check({12'h0, curCount}, 32'h00000001);
    check({1'b0, curSrcAddr}, 32'h00000104);
    check({1'b0, curDstAddr}, 32'h00000204);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000003);
    waitReq(1'b1, 8);
    waitReq(1'b0, 20);
    check({12'h0, curCount}, 32'h00000000);
    check({31'h0, chanOn}, 32'h00000000);
    wr(dtc_pkg::OFS_CONFIG, 32'h00400001);
    check({31'h0, autoReload}, 32'h00000001);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000002);
    for (int c = 0; c < 32; c++) begin
      valid = (c <= 1) || (c >= 10 && c <= 13) || (c >= 18 && c <= 22);
      wr(dtc_pkg::OFS_REQ_SEL, {26'h0, c[4:0], 1'b1});
      reqCode <= c[4:0];
      setReq(1'b1);
      waitReq(1'b1, 6);
      check({31'h0, hit}, {31'h0, valid});
      setReq(1'b0);
      waitReq(1'b0, 20);
    end
    check({31'h0, chanOn}, 32'h00000001);
    wr(dtc_pkg::OFS_CONFIG, 32'h00000003);
    wr(dtc_pkg::OFS_REQ_SEL, 32'h00000000);
    doneDelay <= 4'hA;
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000003);
    waitReq(1'b1, 8);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000006);
    @(negedge clk);
    check({31'h0, chanOn}, 32'h00000001);
    waitReq(1'b0, 20);
    check({31'h0, chanOn}, 32'h00000000);
    check({12'h0, curCount}, 32'h00000000);
    check({1'b0, curSrcAddr}, 32'h00000000);
    check({1'b0, curDstAddr}, 32'h00000000);
    rdChk(dtc_pkg::OFS_TRIG_CTL, 32'h00000000);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000002);
    wr(dtc_pkg::OFS_TRIG_CTL, 32'h00000006);
    @(negedge clk);
    check({31'h0, chanOn}, 32'h00000000);
    tallyAndFinish();
  end
endmodule : testbench
`default_nettype wire
